// >>> iebk_bank.sv
/*
  two interrupt enable registers behind an axi4-lite slave, gating peripheral requests toward the cpu.
  assumes synchronous flag inputs and a well-behaved axi4-lite master.
*/
`timescale 1ns/1ps
`include "iebk_defines.svh"
module iebk_bank (
  input  wire logic                 SYS_CLK_IN,
  input  wire logic                 RST_IN,
  input  wire logic [3:0]           S_AXI_AWADDR_IN,
  input  wire logic                 S_AXI_AWVALID_IN,
  output logic                      S_AXI_AWREADY_OUT,
  input  wire logic [31:0]          S_AXI_WDATA_IN,
  input  wire logic [3:0]           S_AXI_WSTRB_IN,
  input  wire logic                 S_AXI_WVALID_IN,
  output logic                      S_AXI_WREADY_OUT,
  output logic [1:0]                S_AXI_BRESP_OUT,
  output logic                      S_AXI_BVALID_OUT,
  input  wire logic                 S_AXI_BREADY_IN,
  input  wire logic [3:0]           S_AXI_ARADDR_IN,
  input  wire logic                 S_AXI_ARVALID_IN,
  output logic                      S_AXI_ARREADY_OUT,
  output logic [31:0]               S_AXI_RDATA_OUT,
  output logic [1:0]                S_AXI_RRESP_OUT,
  output logic                      S_AXI_RVALID_OUT,
  input  wire logic                 S_AXI_RREADY_IN,
  input  wire iebk_pkg::iebk_word_t FLAG_ONE_IN,
  input  wire iebk_pkg::iebk_word_t FLAG_TWO_IN,
  output iebk_pkg::iebk_word_t      REQ_ONE_OUT,
  output iebk_pkg::iebk_word_t      REQ_TWO_OUT
);
  import iebk_pkg::*;

  iebk_word_t   interrupt_enable_one_q;
  iebk_word_t   interrupt_enable_two_q;
  logic [3:0]   awaddr_q;
  logic         aw_held_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         w_held_q;
  logic         do_write;
  iebk_word_t   wmerge_one;
  iebk_word_t   wmerge_two;

  // ****************************************
  // write channel capture, either order
  // ****************************************
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 4'h0;
    end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= S_AXI_AWADDR_IN;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      w_held_q <= 1'b1;
      wdata_q  <= S_AXI_WDATA_IN;
      wstrb_q  <= S_AXI_WSTRB_IN;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // ready only while nothing of that channel is held and no response pending
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT  <= 1'b0;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_held_q && !S_AXI_BVALID_OUT && !(S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT);
      S_AXI_WREADY_OUT  <= !w_held_q && !S_AXI_BVALID_OUT && !(S_AXI_WVALID_IN && S_AXI_WREADY_OUT);
    end
  end

  assign do_write = aw_held_q && w_held_q && !S_AXI_BVALID_OUT;

  // ****************************************
  // enable registers
  // ****************************************
  // byte strobes merge per lane; only implemented positions store
  always_comb begin
    wmerge_one = interrupt_enable_one_q;
    wmerge_two = interrupt_enable_two_q;
    if (wstrb_q[0]) begin
      wmerge_one[7:0] = wdata_q[7:0];
      wmerge_two[7:0] = wdata_q[7:0];
    end
    if (wstrb_q[1]) begin
      wmerge_one[15:8] = wdata_q[15:8];
      wmerge_two[15:8] = wdata_q[15:8];
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      interrupt_enable_one_q <= `IEBK_RESET_ONE;
      interrupt_enable_two_q <= `IEBK_RESET_TWO;
    end else if (do_write) begin
      if (awaddr_q == `IEBK_OFF_EN_ONE) begin
        interrupt_enable_one_q <= wmerge_one & `IEBK_MASK_ONE;
      end
      if (awaddr_q == `IEBK_OFF_EN_TWO) begin
        interrupt_enable_two_q <= wmerge_two & `IEBK_MASK_TWO;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= `IEBK_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT  <= (awaddr_q == `IEBK_OFF_EN_ONE || awaddr_q == `IEBK_OFF_EN_TWO) ?
                          `IEBK_RESP_OKAY : `IEBK_RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
    end else begin
      S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !(S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT);
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h0000_0000;
      S_AXI_RRESP_OUT  <= `IEBK_RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT  <= `IEBK_RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        `IEBK_OFF_EN_ONE: S_AXI_RDATA_OUT <= {16'h0000, interrupt_enable_one_q & `IEBK_MASK_ONE};
        `IEBK_OFF_EN_TWO: S_AXI_RDATA_OUT <= {16'h0000, interrupt_enable_two_q & `IEBK_MASK_TWO};
        default: begin
          S_AXI_RDATA_OUT <= 32'h0000_0000;
          S_AXI_RRESP_OUT <= `IEBK_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ****************************************
  // request gating
  // ****************************************
  // external input enables (bits 13 and 4 of the first register) still need pin routing by software
  iebk_gate u_gate_one (
    .clk_in    (SYS_CLK_IN),
    .rst_in    (RST_IN),
    .flag_in   (FLAG_ONE_IN),
    .enable_in (interrupt_enable_one_q),
    .mask_in   (`IEBK_MASK_ONE),
    .req_out   (REQ_ONE_OUT)
  );

  iebk_gate u_gate_two (
    .clk_in    (SYS_CLK_IN),
    .rst_in    (RST_IN),
    .flag_in   (FLAG_TWO_IN),
    .enable_in (interrupt_enable_two_q),
    .mask_in   (`IEBK_MASK_TWO),
    .req_out   (REQ_TWO_OUT)
  );

  // ****************************************
  // checks
  // ****************************************
  a_one_unimpl_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (interrupt_enable_one_q & ~`IEBK_MASK_ONE) == 16'h0000)
    else $error("first register holds unimplemented bits");
  a_two_unimpl_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN == `IEBK_OFF_EN_TWO)
    |=> (S_AXI_RDATA_OUT[15:0] & ~`IEBK_MASK_TWO) == 16'h0000)
    else $error("second register reads nonzero unimplemented bits");
  a_write_stores: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (do_write && awaddr_q == `IEBK_OFF_EN_TWO && wstrb_q == 4'hF)
    |=> interrupt_enable_two_q == ($past(wdata_q[15:0]) & `IEBK_MASK_TWO))
    else $error("second register write not stored");
  a_write_one_stores: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (do_write && awaddr_q == `IEBK_OFF_EN_ONE && wstrb_q == 4'hF)
    |=> interrupt_enable_one_q == ($past(wdata_q[15:0]) & `IEBK_MASK_ONE))
    else $error("first register write not stored");
  a_read_returns: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN == `IEBK_OFF_EN_ONE)
    |=> S_AXI_RVALID_OUT && S_AXI_RDATA_OUT[15:0] == $past(interrupt_enable_one_q))
    else $error("read of first register wrong");
  a_req_gated_two: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    1'b1 |=> REQ_TWO_OUT == ($past(FLAG_TWO_IN) & $past(interrupt_enable_two_q)))
    else $error("second bank request not gated by enable");
  a_resp_held: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN) |=> S_AXI_BVALID_OUT)
    else $error("write response dropped before taken");
  // a stray address must never leak into either register, whatever the strobes say
  a_unmapped_ignored: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (do_write && awaddr_q != `IEBK_OFF_EN_ONE && awaddr_q != `IEBK_OFF_EN_TWO)
    |=> $stable(interrupt_enable_one_q) && $stable(interrupt_enable_two_q))
    else $error("unmapped write changed an enable register");
  a_req_gated_one: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    1'b1 |=> REQ_ONE_OUT == ($past(FLAG_ONE_IN) & $past(interrupt_enable_one_q)))
    else $error("first bank request not gated by enable");
  a_rdata_upper_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:16] == 16'h0000)
    else $error("read data upper half not zero");
endmodule : iebk_bank

// >>> iebk_defines.svh
/*
  constants for the interrupt enable bank: register offsets, implemented-bit masks, reset values.
  assumes inclusion by the bank and gate design files of the bank; definitions only.
*/
// What this block does
// - first register bits 15-9 and 4-0 mapped
// - second register enables at bits 13,9,7-5,1,0
// - second register unimplemented bits read zero
// - enable one passes request, zero blocks it
// - implemented bits read/write, reset to zero
`ifndef IEBK_DEFINES_SVH
`define IEBK_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define IEBK_OFF_EN_ONE   4'h0
`define IEBK_OFF_EN_TWO   4'h4
`define IEBK_MASK_ONE     16'hFE1F
`define IEBK_MASK_TWO     16'h22E3
`define IEBK_RESET_ONE    16'h0000
`define IEBK_RESET_TWO    16'h0000
`define IEBK_RESP_OKAY    2'h0
`define IEBK_RESP_SLVERR  2'h2

`endif

// >>> iebk_pkg.sv
/*
  types shared by the interrupt enable bank.
  assumes nothing of its surroundings.
*/
package iebk_pkg;
  typedef logic [15:0] iebk_word_t;
endpackage : iebk_pkg

// >>> iebk_gate.sv
/*
  per-source request gating: a request passes only while its enable is set.
  assumes flags arrive synchronous to the system clock.
*/
`timescale 1ns/1ps
`include "iebk_defines.svh"
module iebk_gate (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire iebk_pkg::iebk_word_t flag_in,
  input  wire iebk_pkg::iebk_word_t enable_in,
  input  wire iebk_pkg::iebk_word_t mask_in,
  output logic      [15:0]       req_out
);
  import iebk_pkg::*;
  // ****************************************
  // gating, registered per bit
  // ****************************************
  for (genvar i = 0; i < 16; i++) begin : g_bit
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        req_out[i] <= 1'b0;
      end else begin
        req_out[i] <= flag_in[i] & enable_in[i] & mask_in[i];
      end
    end
  end

  a_req_follows_en: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> req_out == ($past(flag_in) & $past(enable_in) & $past(mask_in)))
    else $error("request does not follow flag and enable");
  a_req_blocked: assert property (@(posedge clk_in) disable iff (rst_in)
    (enable_in == 16'h0000) |=> (req_out == 16'h0000))
    else $error("request passed with enables clear");
endmodule : iebk_gate

// >>> iebk_src_model.sv
/*
  model of the peripheral request sources: raises the flags the bench commands.
  assumes the system clock and reset of the bank.
*/
`timescale 1ns/1ps
module iebk_src_model (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire iebk_pkg::iebk_word_t pat_one_in,
  input  wire iebk_pkg::iebk_word_t pat_two_in,
  output iebk_pkg::iebk_word_t      flag_one_out,
  output iebk_pkg::iebk_word_t      flag_two_out
);
  import iebk_pkg::*;
  // ****************************************
  // flag sources
  // ****************************************
  // external inputs (first reg bits 13, 4) are taken as already routed to a pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_one_out <= 16'h0000;
      flag_two_out <= 16'h0000;
    end else begin
      flag_one_out <= pat_one_in;
      flag_two_out <= pat_two_in;
    end
  end
endmodule : iebk_src_model

// >>> iebk_bank_bench.sv
/*
  self-checking bench of the interrupt enable bank over axi4-lite.
  assumes the design files and the source model are compiled first.
*/
`timescale 1ns/1ps
`include "iebk_defines.svh"
module iebk_bank_bench;
  import iebk_pkg::*;
  logic        clk          = 1'b0;
  logic        rst          = 1'b1;
  logic        awv          = 1'b0;
  logic        wv           = 1'b0;
  logic        br           = 1'b0;
  logic        arv          = 1'b0;
  logic        rr           = 1'b0;
  logic        bv;
  logic        rv;
  logic        awr;
  logic        wr;
  logic        arr;
  logic [3:0]  awa          = 4'h0;
  logic [3:0]  ara          = 4'h0;
  logic [3:0]  ws           = 4'hF;
  logic [31:0] wd           = 32'h0000_0000;
  logic [31:0] rd;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  resp;
  iebk_word_t  pat1         = 16'h0000;
  iebk_word_t  pat2         = 16'h0000;
  iebk_word_t  fl1;
  iebk_word_t  fl2;
  iebk_word_t  rq1;
  iebk_word_t  rq2;
  int          bad_count    = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  always #12.5 clk = ~clk;
  iebk_src_model i_src (.clk_in(clk), .rst_in(rst), .pat_one_in(pat1), .pat_two_in(pat2),
    .flag_one_out(fl1), .flag_two_out(fl2));
  iebk_bank i_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .FLAG_ONE_IN(fl1),
    .FLAG_TWO_IN(fl2), .REQ_ONE_OUT(rq1), .REQ_TWO_OUT(rq2));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // the wait is bounded only by the global cycle ceiling
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    awa <= a;
    wd  <= d;
    ws  <= s;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awv && awr) begin
        awv <= 1'b0;
      end
      if (wv && wr) begin
        wv <= 1'b0;
      end
      if (bv && br) begin
        resp = bresp;
        br   <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic done;
    done = 1'b0;
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arv && arr) begin
        arv <= 1'b0;
      end
      if (rv && rr) begin
        d    = rd;
        resp = rresp;
        rr   <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask : axi_rd
  // flags need one edge into the source model and one through the gate
  task automatic flags(input iebk_word_t f1, input iebk_word_t f2);
    pat1 <= f1;
    pat2 <= f2;
    repeat (3) @(posedge clk);
  endtask : flags
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] v;
    flags(16'hFFFF, 16'hFFFF);
    chk("req one at reset", rq1, 16'h0000);
    chk("req two at reset", rq2, 16'h0000);
    axi_rd(`IEBK_OFF_EN_ONE, v);
    chk("en one reset", v, {16'h0000, `IEBK_RESET_ONE});
    axi_rd(`IEBK_OFF_EN_TWO, v);
    chk("en two reset", v, {16'h0000, `IEBK_RESET_TWO});
    $display("test reset done");
  endtask : t_reset
  task automatic t_all_ones;
    logic [31:0] v;
    axi_wr(`IEBK_OFF_EN_ONE, 32'hFFFF_FFFF, 4'hF);
    chk("wr one resp", resp, `IEBK_RESP_OKAY);
    axi_wr(`IEBK_OFF_EN_TWO, 32'hFFFF_FFFF, 4'hF);
    chk("wr two resp", resp, `IEBK_RESP_OKAY);
    axi_rd(`IEBK_OFF_EN_ONE, v);
    chk("en one ones", v, 32'h0000_FE1F);
    axi_rd(`IEBK_OFF_EN_TWO, v);
    chk("en two ones", v, 32'h0000_22E3);
    flags(16'hFFFF, 16'hFFFF);
    chk("req one all", rq1, 16'hFE1F);
    chk("req two all", rq2, 16'h22E3);
    $display("test all ones done");
  endtask : t_all_ones
  task automatic t_gating;
    logic [31:0] v;
    axi_wr(`IEBK_OFF_EN_ONE, 32'h0000_A5A5, 4'hF);
    axi_wr(`IEBK_OFF_EN_TWO, 32'h0000_0000, 4'hF);
    axi_rd(`IEBK_OFF_EN_ONE, v);
    chk("en one pattern", v, 32'h0000_A405);
    axi_rd(`IEBK_OFF_EN_TWO, v);
    chk("en two cleared", v, 32'h0000_0000);
    flags(16'h0F0F, 16'hFFFF);
    chk("req one gated", rq1, 16'h0405);
    chk("req two masked", rq2, 16'h0000);
    flags(16'h0000, 16'h0000);
    chk("req one no flag", rq1, 16'h0000);
    $display("test gating done");
  endtask : t_gating
  task automatic t_unmapped;
    logic [31:0] v;
    axi_wr(4'h8, 32'hFFFF_FFFF, 4'hF);
    chk("wr unmapped resp", resp, `IEBK_RESP_SLVERR);
    axi_rd(4'h8, v);
    chk("rd unmapped data", v, 32'h0000_0000);
    chk("rd unmapped resp", resp, `IEBK_RESP_SLVERR);
    axi_rd(`IEBK_OFF_EN_ONE, v);
    chk("en one kept", v, 32'h0000_A405);
    $display("test unmapped done");
  endtask : t_unmapped
  // byte lanes: lane 1 alone, the ignored upper lanes, then lane 0 alone
  task automatic t_strobes;
    logic [31:0] v;
    axi_wr(`IEBK_OFF_EN_TWO, 32'hFFFF_FFFF, 4'h2);
    axi_rd(`IEBK_OFF_EN_TWO, v);
    chk("en two upper lane", v, 32'h0000_2200);
    axi_wr(`IEBK_OFF_EN_TWO, 32'hFFFF_FFFF, 4'hC);
    axi_rd(`IEBK_OFF_EN_TWO, v);
    chk("en two high lanes", v, 32'h0000_2200);
    axi_wr(`IEBK_OFF_EN_TWO, 32'h0000_0021, 4'h1);
    axi_rd(`IEBK_OFF_EN_TWO, v);
    chk("en two lower lane", v, 32'h0000_2221);
    flags(16'h0000, 16'hFFFF);
    chk("req two lanes", rq2, 16'h2221);
    chk("req one idle", rq1, 16'h0000);
    $display("test strobes done");
  endtask : t_strobes
  // reset in mid-run must clear both registers and the requests
  task automatic t_rereset;
    logic [31:0] v;
    flags(16'hFFFF, 16'hFFFF);
    chk("req one before reset", rq1, 16'hA405);
    chk("req two before reset", rq2, 16'h2221);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("req one in reset", rq1, 16'h0000);
    chk("ar ready in reset", arr, 1'b0);
    rst <= 1'b0;
    @(posedge clk);
    chk("ar ready first edge", arr, 1'b0);
    @(posedge clk);
    chk("ar ready second edge", arr, 1'b1);
    axi_rd(`IEBK_OFF_EN_ONE, v);
    chk("en one rereset", v, 32'h0000_0000);
    axi_rd(`IEBK_OFF_EN_TWO, v);
    chk("en two rereset", v, 32'h0000_0000);
    flags(16'hFFFF, 16'hFFFF);
    chk("req one after reset", rq1, 16'h0000);
    chk("req two after reset", rq2, 16'h0000);
    $display("test rereset done");
  endtask : t_rereset
  // ****************************************
  // sequence and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_all_ones();
    t_gating();
    t_unmapped();
    t_strobes();
    t_rereset();
    close_out();
  end
endmodule : iebk_bank_bench
